// >>> pkg/halt_standby_map.vh
// constants for the halt standby controller: register offsets, fields, timing
// assumes apb byte addressing with one aligned 32-bit word per register
`ifndef HALT_STANDBY_MAP_VH
`define HALT_STANDBY_MAP_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_INT_STATUS  12'h008
`define OFS_INT_MASK    12'h00C
`define OFS_PC          12'h010

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define CTRL_WIDE_SEL   0
`define CTRL_RC_MODE    1
`define CTRL_HALT_REQ   2
`define ST_HALTED       0
`define ST_WAKE_OK      1
`define EV_ENTER        0
`define EV_WAKE         1
`define EV_SERIAL       2
`define EV_REFUSED      3
`define EV_BITS         4

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define CTRL_RESET      3'h0
`define PC_RESET        12'h000
`define CYCLE_CLOCKS    4
`define CLK_PERIOD_NS   10
`define CLEAR_MIN_MS    10
`define CLEAR_MIN_CYCLES ((`CLEAR_MIN_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> design/cycle_divider.v
// instruction cycle timer: one tick every CYCLE_CLOCKS enabled clocks
// assumes pclk domain, run gated off while halted
`timescale 1ns/1ps
module cycle_divider #(
   parameter CYCLE_CLOCKS = 4
) (
   input  wire pclk,    // system clock
   input  wire presetn, // async reset, active low
   input  wire ce,      // clock enable
   input  wire run,     // processor clocking allowed
   output reg  tick     // one-cycle pulse at end of instruction cycle
);
   reg [3:0] cnt_r;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         tick  <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            cnt_r <= 4'h0;
            tick  <= 1'b0;
         end else if (cnt_r == CYCLE_CLOCKS - 1) begin
            cnt_r <= 4'h0;
            tick  <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 4'h1;
            tick  <= 1'b0;
         end
      end
   end
endmodule

// >>> design/release_detect.v
// halt release qualification from wake port, serial completion and mode
// assumes all inputs synchronous to pclk
`timescale 1ns/1ps
module release_detect (
   input  wire [3:0] wake_port,   // wake_port_bit0..bit3
   input  wire       wide_sel,    // use bits 0..3 instead of bit 3
   input  wire       rc_mode,     // rc oscillator selected
   input  wire       serial_done, // serial transfer completion pulse
   output wire       entry_ok,    // selected wake bits all high
   output wire       wake_rel,    // wake release active
   output wire       serial_rel   // serial release active
);
   assign entry_ok   = wide_sel ? (&wake_port) : wake_port[3];
   // low selected bit releases, rc only
   assign wake_rel   = rc_mode & ~entry_ok;
   // serial release without condition in rc
   assign serial_rel = rc_mode & serial_done;
endmodule

// >>> design/halt_standby_control.v
// halt standby controller with apb register access and interrupt
// assumes apb master in pclk domain; external clear has its own input, separate from presetn
`timescale 1ns/1ps
`include "halt_standby_map.vh"
module halt_standby_control #(
   parameter PC_W = 12
) (
   input  wire        pclk,                 // system clock, 100 MHz
   input  wire        presetn,              // async reset, active low
   input  wire        ce,                   // clock enable, freezes state
   input  wire        external_clear_input, // external clear, active low
   input  wire [3:0]  wake_port,            // wake port bits 0..3
   input  wire        halt_instr,           // halt instruction issued, pulse
   input  wire        serial_done,          // serial transfer complete, pulse
   input  wire        psel,                 // apb select
   input  wire        penable,              // apb enable
   input  wire        pwrite,               // apb write
   input  wire [11:0] paddr,                // apb address
   input  wire [31:0] pwdata,               // apb write data
   output wire        pready,               // apb ready
   output reg  [31:0] prdata,               // apb read data
   output wire        pslverr,              // apb error
   output wire        halted,               // core in standby
   output wire        core_run,             // processor clocking allowed
   output wire        cycle_tick,           // instruction cycle tick
   output reg  [PC_W-1:0] program_counter,  // fetch address
   output wire        irq                   // level interrupt
);
   localparam ST_RUN  = 1'b0;
   localparam ST_HALT = 1'b1;

   reg        state_r;
   reg [2:0]  ctrl_r;
   reg [`EV_BITS-1:0] ist_r;
   reg [`EV_BITS-1:0] imask_r;
   reg        clr_q_r;
   wire       entry_ok;
   wire       wake_rel;
   wire       serial_rel;
   wire       wr_en;
   wire       rd_en;
   wire       hit;
   wire       halt_go;
   wire       enter;
   wire       refused;
   wire       leave;
   wire [`EV_BITS-1:0] ev;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function is_mapped;
      input [11:0] a;
      begin
         if (a == `OFS_CTRL)
            is_mapped = 1'b1;
         else if (a == `OFS_STATUS)
            is_mapped = 1'b1;
         else if (a == `OFS_INT_STATUS)
            is_mapped = 1'b1;
         else if (a == `OFS_INT_MASK)
            is_mapped = 1'b1;
         else if (a == `OFS_PC)
            is_mapped = 1'b1;
         else
            is_mapped = 1'b0;
      end
   endfunction

   assign pready  = 1'b1;
   assign hit     = is_mapped(paddr);
   assign pslverr = psel & penable & ~hit;
   assign wr_en   = ce & psel & penable & pwrite & hit;
   assign rd_en   = psel & ~penable & ~pwrite;

   release_detect u_rel (
      .wake_port   (wake_port),
      .wide_sel    (ctrl_r[`CTRL_WIDE_SEL]),
      .rc_mode     (ctrl_r[`CTRL_RC_MODE]),
      .serial_done (serial_done),
      .entry_ok    (entry_ok),
      .wake_rel    (wake_rel),
      .serial_rel  (serial_rel)
   );

   assign core_run = (state_r == ST_RUN);
   assign halted   = ~core_run;

   cycle_divider #(
      .CYCLE_CLOCKS (`CYCLE_CLOCKS)
   ) u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .run     (core_run),
      .tick    (cycle_tick)
   );

   // ------------------------------------------------------------
   // standby sequencing
   // ------------------------------------------------------------
   // halt comes from the core or from a software write of the request bit
   assign halt_go = (halt_instr | (wr_en & (paddr == `OFS_CTRL) &
                    pwdata[`CTRL_HALT_REQ])) & core_run;
   // enter only with the selected wake bits high
   assign enter   = halt_go & entry_ok;
   assign refused = halt_go & ~entry_ok;
   // release during halt cycle is the far side's duty; entry wins here
   assign leave   = (state_r == ST_HALT) & (wake_rel | serial_rel);
   assign ev      = {refused, leave & serial_rel, leave & wake_rel & ~serial_rel, enter};

   // external clear is a level; registered once so a glitch-free low ends standby
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clr_q_r <= 1'b1;
      else if (ce)
         clr_q_r <= external_clear_input;
   end

   // clear ends standby and zeros pc
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r         <= ST_RUN;
         program_counter <= `PC_RESET;
      end else if (ce) begin
         if (!clr_q_r) begin
            state_r         <= ST_RUN;
            program_counter <= `PC_RESET;
         end else begin
            case (state_r)
               ST_RUN: begin
                  if (enter)
                     state_r <= ST_HALT;
                  // pc advances only on cycle ticks while running
                  else if (cycle_tick)
                     program_counter <= program_counter + {{(PC_W-1){1'b0}}, 1'b1};
               end
               ST_HALT: begin
                  if (leave)
                     state_r <= ST_RUN;
               end
               default: state_r <= ST_RUN;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // control kept across standby; only reset clears it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= `CTRL_RESET;
         imask_r <= {`EV_BITS{1'b0}};
      end else if (wr_en) begin
         if (paddr == `OFS_CTRL)
            ctrl_r <= {1'b0, pwdata[`CTRL_RC_MODE], pwdata[`CTRL_WIDE_SEL]};
         else if (paddr == `OFS_INT_MASK)
            imask_r <= pwdata[`EV_BITS-1:0];
      end
   end

   // sticky events, write one clears, a new event wins over the clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ist_r <= {`EV_BITS{1'b0}};
      else if (ce) begin
         if (wr_en && paddr == `OFS_INT_STATUS)
            ist_r <= (ist_r & ~pwdata[`EV_BITS-1:0]) | ev;
         else
            ist_r <= ist_r | ev;
      end
   end

   assign irq = |(ist_r & imask_r);

   // read data registered in setup phase, valid in access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (ce && rd_en) begin
         if (paddr == `OFS_CTRL)
            prdata <= {29'h0000_0000, ctrl_r};
         else if (paddr == `OFS_STATUS)
            prdata <= {30'h0000_0000, entry_ok, halted};
         else if (paddr == `OFS_INT_STATUS)
            prdata <= {28'h0000_0000, ist_r};
         else if (paddr == `OFS_INT_MASK)
            prdata <= {28'h0000_0000, imask_r};
         else if (paddr == `OFS_PC)
            prdata <= {{(32-PC_W){1'b0}}, program_counter};
         else
            prdata <= 32'h0000_0000;
      end
   end
endmodule

// >>> sim/halt_standby_chk_sva.sv
// checker watching the halt standby controller ports
// assumes one pclk domain with ce held high
`timescale 1ns/1ps
module halt_standby_chk #(
   parameter PC_W = 12
) (
   input wire            pclk,
   input wire            presetn,
   input wire            external_clear_input,
   input wire [3:0]      wake_port,
   input wire            halt_instr,
   input wire            serial_done,
   input wire            halted,
   input wire            core_run,
   input wire            cycle_tick,
   input wire [PC_W-1:0] program_counter
);
   // ----
   // standby properties
   // ----
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_entry_gate: assert property (halt_instr && !halted && !wake_port[3] |=> !halted)
      else $error("standby entered with wake bit3 low");
   chk_clear_exit: assert property (!external_clear_input |-> ##2 !halted)
      else $error("clear did not end standby");
   chk_clear_pc: assert property (!external_clear_input |-> ##2 program_counter == '0)
      else $error("clear did not restart at zero");
   // clear is registered once, so a one-cycle low still ends standby a cycle later; two high clear samples are required
   chk_hold_halt: assert property (halted && external_clear_input &&
      $past(external_clear_input) && (&wake_port) && !serial_done |=> halted)
      else $error("standby left without a release");
   chk_pc_frozen: assert property (halted && $past(halted) |-> $stable(program_counter))
      else $error("program counter moved in standby");
   chk_tick_gap: assert property (cycle_tick |=> !cycle_tick [*3])
      else $error("instruction cycle shorter than four clocks");
   chk_tick_stop: assert property (halted && $past(halted) && $past(halted, 2)
      |-> !cycle_tick)
      else $error("cycle tick while halted");
   chk_run_gate: assert property (core_run == !halted)
      else $error("core clocking not gated by standby");
endmodule

bind halt_standby_control halt_standby_chk #(.PC_W(PC_W)) i_chk (.pclk, .presetn,
   .external_clear_input, .wake_port, .halt_instr, .serial_done, .halted, .core_run,
   .cycle_tick, .program_counter);

// >>> sim/standby_peer.sv
// far side: clear circuit, wake inputs and serial peer
// assumes the bench calls its tasks; acts only right after pclk edges
`timescale 1ns/1ps
module standby_peer #(
   parameter CLEAR_CYCLES = 8
) (
   input  wire       pclk,
   input  wire       halt_instr,
   output reg        external_clear_input,
   output reg  [3:0] wake_port,
   output reg        serial_done
);
   initial begin
      external_clear_input = 1'b1;
      wake_port = 4'hF;
      serial_done = 1'b0;
   end
   task gap;
      @(posedge pclk);
      while (halt_instr) @(posedge pclk);
   endtask
   task set_wake(input logic [3:0] w);
      gap;
      wake_port <= w;
   endtask
   task serial_pulse;
      gap;
      serial_done <= 1'b1;
      @(posedge pclk);
      serial_done <= 1'b0;
   endtask
   task clear_low;
      gap;
      external_clear_input <= 1'b0;
      repeat (CLEAR_CYCLES) @(posedge pclk);
      external_clear_input <= 1'b1;
   endtask
endmodule

// >>> sim/halt_standby_control_tb_top.sv
// self-checking bench for the halt standby controller
// assumes standby_peer drives clear, wake and serial pins
`timescale 1ns/1ps
`include "halt_standby_map.vh"
module halt_standby_control_tb_top;
   logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, halt_instr = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd, seed = 32'h0000_0033;
   wire         external_clear_input, serial_done, pready, pslverr, halted, core_run;
   wire         cycle_tick, irq;
   wire  [3:0]  wake_port;
   wire  [31:0] prdata;
   wire  [11:0] program_counter;
   int          num_errors = 0, total_checks = 0, exp_ev = 0, exp_halt = 0;
   halt_standby_control i_dut (.pclk, .presetn, .ce, .external_clear_input, .wake_port,
      .halt_instr, .serial_done, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .halted, .core_run, .cycle_tick, .program_counter, .irq);
   standby_peer #(.CLEAR_CYCLES(8)) i_peer (.pclk, .halt_instr, .external_clear_input,
      .wake_port, .serial_done);
   initial forever #5 pclk = ~pclk;
   task cyc(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xorshift = t ^ (t << 5);
   endfunction
   task check(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task summarize;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         num_errors++;
         summarize;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task halt_try(input logic [3:0] w, input int wide);
      i_peer.set_wake(w);
      @(posedge pclk);
      halt_instr <= 1'b1;
      @(posedge pclk);
      halt_instr <= 1'b0;
      exp_halt = wide ? (w == 4'hF) : w[3];
      exp_ev |= exp_halt ? 1 : 8;
      cyc(2);
      check("halted", {31'd0, halted}, exp_halt);
   endtask
   // kind 0 drops wake bits 3 and 0, kind 1 completes a serial transfer
   task release_by(input int kind, input int rc);
      logic [11:0] pc_h;
      pc_h = program_counter;
      if (kind == 0) i_peer.set_wake(4'h6);
      else i_peer.serial_pulse;
      #1;
      // a running core keeps fetching, so the pc is only frozen while halted
      if (exp_halt)
         check("pc", {20'd0, program_counter}, {20'd0, pc_h});
      else
         check("core_run", {31'd0, core_run}, 1);
      if (rc && exp_halt) begin
         exp_halt = 0;
         exp_ev |= kind ? 4 : 2;
      end
      cyc(2);
      check("halted", {31'd0, halted}, exp_halt);
      apb(0, `OFS_INT_STATUS, 0);
      check("int_status", rd, exp_ev);
      check("irq", {31'd0, irq}, exp_ev != 0);
      apb(1, `OFS_INT_STATUS, 32'h0000_000F);
      exp_ev = 0;
      i_peer.set_wake(4'hF);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `OFS_CTRL, 0);
      check("ctrl", rd, `CTRL_RESET);
      apb(0, `OFS_PC, 0);
      check("pc_reg", rd, `PC_RESET);
      apb(0, 12'h040, 0);
      check("unmapped", {rd[30:0], err}, 1);
      apb(1, `OFS_INT_MASK, 32'h0000_000F);
      $display("test registers done");
      halt_try(4'h7, 0);
      release_by(0, 0);
      halt_try(4'hF, 0);
      release_by(0, 0);
      release_by(1, 0);
      fork
         i_peer.clear_low;
         begin
            cyc(4);
            check("halted", {31'd0, halted}, 0);
            check("pc", {20'd0, program_counter}, 0);
         end
      join
      $display("test ceramic done");
      apb(1, `OFS_INT_MASK, 32'h0000_000F);
      apb(1, `OFS_INT_STATUS, 32'h0000_000F);
      apb(1, `OFS_CTRL, 32'h0000_0002);
      for (int k = 0; k < 2; k++) begin
         halt_try(4'hF, 0);
         release_by(k, 1);
      end
      apb(1, `OFS_CTRL, 32'h0000_0003);
      for (int k = 0; k < 6; k++) begin
         seed = xorshift(seed);
         halt_try(seed[4] ? 4'hF : seed[3:0], 1);
         release_by(0, 1);
      end
      // software halt request with all wake bits high, then serial release
      apb(1, `OFS_CTRL, 32'h0000_0007);
      exp_halt = 1;
      exp_ev |= 1;
      cyc(1);
      check("halted", {31'd0, halted}, exp_halt);
      release_by(1, 1);
      $display("test rc done");
      summarize;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      summarize;
   end
endmodule
